// [hdl/rpr_defs.svh]
// Byte codes, frame limits and timing counts of the poll responder
`ifndef RPR_DEFS_SVH
`define RPR_DEFS_SVH
`define RPR_POLL_LEAD 8'h25
`define RPR_SAVE_LEAD 8'h2B
`define RPR_WAKE_LEAD 8'h2D
`define RPR_REPLY_LEAD 8'hA5
`define RPR_CHAR_0 8'h30
`define RPR_CHAR_DOT 8'h2E
`define RPR_CHAR_COLON 8'h3A
`define RPR_FN_READ 8'h03
`define RPR_FN_WRITE1 8'h06
`define RPR_FN_WRITEN 8'h10
`define RPR_CRC_POLY 16'hA001
`define RPR_CRC_INIT 16'hFFFF
`define RPR_MAX_READ 16'h007D
`define RPR_MAX_WRITE 16'h0008
`define RPR_GAP_US 4010
`define RPR_CLK_MHZ 125
`define RPR_GAP_CYCLES (`RPR_GAP_US * `RPR_CLK_MHZ)
`endif

// [hdl/rpr_pkg.sv]
// Types shared by the poll responder
package rpr_pkg;
   typedef struct packed {
      logic valid;
      logic parity;
      logic [7:0] data;
   } rpr_byte_type;
   typedef struct packed {
      logic rd;
      logic wr;
      logic [15:0] addr;
      logic [15:0] wdata;
   } rpr_reg_req_type;
   typedef enum logic [4:0] {
      ST_RX = 5'b00001,
      ST_COMMIT = 5'b00010,
      ST_SEND = 5'b00100,
      ST_FETCH = 5'b01000,
      ST_LATCH = 5'b10000
   } rpr_state_type;
endpackage : rpr_pkg

// [hdl/rpr_poll_responder.sv]
// Poll responder: ASCII poll protocol and Modbus RTU framing over a byte stream
`timescale 1ns/100ps
`include "rpr_defs.svh"
// Function
// - Readings sent only in answer to polls
// - Poll frame: 0x25, identifier, checksum
// - Identifier is two ASCII digits, leading zero
// - Request checksum sums the two identifier bytes
// - Reply only when identifier matches own
// - Reply: 0xA5, identifier, speed, colon, level, checksum
// - Speed text: decimal, dot, three truncated digits
// - Level text: metres, dot, three truncated digits
// - Reply checksum: identifier plus speed bytes
// - Frame 0x2B enters power save
// - Frame 0x2D leaves power save
// - Modbus characters: eight bits, even parity
// - Each register holds one 16-bit value
// - Multi-register reads and writes are handled
// - Slave only, never starts traffic
// - Request: address, function, start, count, CRC
// - Read reply: echo, byte count, data, CRC
// - Modbus address equals own identifier
// - Function codes 0x03, 0x06 and 0x10 supported
module rpr_poll_responder #(
   parameter int GAP_CYCLES = `RPR_GAP_CYCLES
) (
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   input wire logic MODE_MODBUS,
   input wire logic [7:0] UNIT_ID,
   input wire logic [15:0] SPEED_INT,
   input wire logic [9:0] SPEED_MILLI,
   input wire logic [15:0] LEVEL_INT,
   input wire logic [9:0] LEVEL_MILLI,
   input wire rpr_pkg::rpr_byte_type RX_BYTE,
   input wire logic TX_READY,
   output rpr_pkg::rpr_byte_type TX_BYTE,
   output logic TX_EN,
   output logic POWER_SAVE,
   output rpr_pkg::rpr_reg_req_type REG_REQ,
   input wire logic [15:0] REG_RDATA
);
   import rpr_pkg::*;
   // ***************
   // Functions
   // ***************
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      logic [15:0] r;
      r = c ^ {8'h00, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ `RPR_CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_step
   function automatic logic [2:0] num_digits(input logic [15:0] v);
      return (v >= 16'h2710) ? 3'h5 : (v >= 16'h03E8) ? 3'h4 : (v >= 16'h0064) ? 3'h3 :
         (v >= 16'h000A) ? 3'h2 : 3'h1;
   endfunction : num_digits
   function automatic logic [7:0] dec_char(input logic [15:0] v, input logic [2:0] pos);
      logic [15:0] q;
      case (pos)
         3'h0: q = v;
         3'h1: q = v / 16'h000A;
         3'h2: q = v / 16'h0064;
         3'h3: q = v / 16'h03E8;
         default: q = v / 16'h2710;
      endcase
      return `RPR_CHAR_0 + 8'(q % 16'h000A);
   endfunction : dec_char
   // Integer digits without leading zeros, then dot and three milli digits
   function automatic logic [7:0] text_char(input logic [15:0] iv, input logic [9:0] mv, input logic [4:0] p);
      logic [4:0] n;
      n = {2'h0, num_digits(iv)};
      if (p < n) return dec_char(iv, 3'(n - 5'h1 - p));
      else if (p == n) return `RPR_CHAR_DOT;
      else return dec_char({6'h00, mv}, 3'(n + 5'h3 - p));
   endfunction : text_char
   // ***************
   // Receive side
   // ***************
   rpr_state_type state, next_state;
   logic [7:0] rx_idx, cmd, id0, id1, fun, bcnt;
   logic [15:0] start, count, crc_rx;
   logic [15:0] wbuf [0:7];
   logic skip;
   logic [19:0] gap_cnt;
   logic [7:0] b;
   logic rx_take, par_bad, poll_end, poll_ok, mb_end, mb_ok, req_ok, lead_ok;
   logic [7:0] own_hi, own_lo, mb_last, w_off;
   logic [15:0] crc_next;

   // Decode of the incoming byte; bytes during a reply are ignored (half duplex)
   assign b = RX_BYTE.data;
   assign rx_take = RX_BYTE.valid && (state == ST_RX) && !skip;
   assign par_bad = MODE_MODBUS && (RX_BYTE.parity != ^b);
   assign own_hi = `RPR_CHAR_0 + 8'(UNIT_ID / 8'h0A);
   assign own_lo = `RPR_CHAR_0 + 8'(UNIT_ID % 8'h0A);
   assign lead_ok = (b == `RPR_POLL_LEAD) || (b == `RPR_SAVE_LEAD) || (b == `RPR_WAKE_LEAD);
   assign poll_end = rx_take && !MODE_MODBUS && (rx_idx == 8'h03);
   // Checksum over the identifier only, then identifier match
   assign poll_ok = poll_end && (b == 8'(id0 + id1)) && (id0 == own_hi) && (id1 == own_lo);
   assign crc_next = crc_step((rx_idx == 8'h00) ? `RPR_CRC_INIT : crc_rx, b);
   assign mb_last = (fun == `RPR_FN_WRITEN) ? 8'(bcnt + 8'h08) : 8'h07;
   assign mb_end = rx_take && MODE_MODBUS && !par_bad && (rx_idx >= 8'h07) && (rx_idx == mb_last);
   assign req_ok = (fun == `RPR_FN_READ) ? (count != 16'h0000 && count <= `RPR_MAX_READ) :
      (fun == `RPR_FN_WRITE1) ? 1'b1 :
      (count != 16'h0000 && count <= `RPR_MAX_WRITE && {8'h00, bcnt} == 16'(count << 1));
   // Residue over a frame including its own CRC is zero when intact
   assign mb_ok = mb_end && (crc_next == 16'h0000) && req_ok;
   assign w_off = 8'(rx_idx - 8'h07);
   // Poll protocol and Modbus frame position and skip flag
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         rx_idx <= 8'h00;
         skip <= 1'b0;
      end else if (gap_cnt == 20'(GAP_CYCLES)) begin
         rx_idx <= 8'h00; // Stale partial frame after line silence
         skip <= 1'b0;
      end else if (rx_take && !MODE_MODBUS) begin
         if (rx_idx == 8'h00) rx_idx <= lead_ok ? 8'h01 : 8'h00;
         else if (rx_idx == 8'h03) rx_idx <= 8'h00;
         else rx_idx <= rx_idx + 8'h01;
      end else if (rx_take) begin
         if (par_bad) skip <= 1'b1;
         else if (rx_idx == 8'h00 && b != UNIT_ID) skip <= 1'b1;
         else if (rx_idx == 8'h01 && b != `RPR_FN_READ && b != `RPR_FN_WRITE1 && b != `RPR_FN_WRITEN) skip <= 1'b1;
         else if (rx_idx == 8'h06 && fun == `RPR_FN_WRITEN && b > 8'h10) skip <= 1'b1;
         rx_idx <= mb_end ? 8'h00 : rx_idx + 8'h01;
      end
   end

   // Field registers; the write buffer lets a bad CRC discard the whole frame
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         cmd <= 8'h00;
         id0 <= 8'h00;
         id1 <= 8'h00;
         fun <= 8'h00;
         bcnt <= 8'h00;
         start <= 16'h0000;
         count <= 16'h0000;
         crc_rx <= `RPR_CRC_INIT;
      end else if (rx_take) begin
         crc_rx <= crc_next;
         case (rx_idx)
            8'h00: cmd <= b;
            8'h01: begin
               id0 <= b;
               fun <= b;
            end
            8'h02: begin
               id1 <= b;
               start[15:8] <= b;
            end
            8'h03: start[7:0] <= b;
            8'h04: count[15:8] <= b;
            8'h05: count[7:0] <= b;
            8'h06: bcnt <= b;
            default: ;
         endcase
      end
   end

   // Write-multiple data, high byte first into 16-bit slots
   always_ff @(posedge CLK_SYS) begin
      if (rx_take && fun == `RPR_FN_WRITEN && rx_idx >= 8'h07 && w_off < 8'h10) begin
         if (w_off[0]) wbuf[w_off[3:1]][7:0] <= b;
         else wbuf[w_off[3:1]][15:8] <= b;
      end
   end
   // Inter-frame silence counter, runs only while a frame is open or skipped
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || RX_BYTE.valid || (rx_idx == 8'h00 && !skip) || gap_cnt == 20'(GAP_CYCLES)) gap_cnt <= 20'h00000;
      else gap_cnt <= gap_cnt + 20'h00001;
   end
   // Power save mode follows the addressed + and - commands
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) POWER_SAVE <= 1'b0;
      else if (poll_ok && cmd == `RPR_SAVE_LEAD) POWER_SAVE <= 1'b1;
      else if (poll_ok && cmd == `RPR_WAKE_LEAD) POWER_SAVE <= 1'b0;
   end

   // ***************
   // Reply side
   // ***************
   logic [7:0] tx_idx, tx_len, tsum, poll_byte, mb_byte, tx_data, tx_off;
   logic [15:0] s_int, l_int, rdata, crc_tx;
   logic [9:0] s_mil, l_mil;
   logic [4:0] s_len, l_len;
   logic [3:0] wr_k, wr_n;
   logic fetched, need_fetch, tx_done, poll_go, mb_read;
   assign poll_go = poll_ok && (cmd == `RPR_POLL_LEAD);
   assign mb_read = (fun == `RPR_FN_READ);
   assign s_len = 5'(num_digits(s_int)) + 5'h4;
   assign l_len = 5'(num_digits(l_int)) + 5'h4;
   assign tx_len = !MODE_MODBUS ? 8'(8'h05 + s_len + l_len) : mb_read ? 8'(8'h05 + (count[7:0] << 1)) : 8'h08;
   assign tx_off = 8'(tx_idx - 8'h03);
   assign tx_done = TX_BYTE.valid && TX_READY;
   assign wr_n = (fun == `RPR_FN_WRITE1) ? 4'h1 : count[3:0];
   // Register value is fetched just before its high byte goes out
   assign need_fetch = MODE_MODBUS && mb_read && tx_idx >= 8'h03 && tx_idx < 8'(tx_len - 8'h02) && !tx_off[0] && !fetched;
   // Poll reply byte at the current index
   assign poll_byte = (tx_idx == 8'h00) ? `RPR_REPLY_LEAD : (tx_idx == 8'h01) ? own_hi : (tx_idx == 8'h02) ? own_lo :
      (tx_idx < 8'(8'h03 + s_len)) ? text_char(s_int, s_mil, 5'(tx_off)) :
      (tx_idx == 8'(8'h03 + s_len)) ? `RPR_CHAR_COLON :
      (tx_idx < 8'(8'h04 + s_len + l_len)) ? text_char(l_int, l_mil, 5'(tx_idx - 8'h04 - s_len)) : tsum;
   // Modbus reply byte; write replies echo start and count or value
   assign mb_byte = (tx_idx == 8'(tx_len - 8'h02)) ? crc_tx[7:0] : (tx_idx == 8'(tx_len - 8'h01)) ? crc_tx[15:8] :
      (tx_idx == 8'h00) ? UNIT_ID : (tx_idx == 8'h01) ? fun :
      (mb_read && tx_idx == 8'h02) ? 8'(count[7:0] << 1) : mb_read ? (tx_off[0] ? rdata[7:0] : rdata[15:8]) :
      (tx_idx == 8'h02) ? start[15:8] : (tx_idx == 8'h03) ? start[7:0] :
      (tx_idx == 8'h04) ? count[15:8] : count[7:0];
   assign tx_data = MODE_MODBUS ? mb_byte : poll_byte;
   // Sequencer
   always_comb begin
      next_state = state;
      case (state)
         ST_RX: begin
            if (poll_go) next_state = ST_SEND;
            else if (mb_ok) next_state = mb_read ? ST_SEND : ST_COMMIT;
         end
         ST_COMMIT: if (wr_k == wr_n) next_state = ST_SEND;
         ST_SEND: begin
            if (!TX_BYTE.valid && tx_idx == tx_len) next_state = ST_RX;
            else if (!TX_BYTE.valid && need_fetch) next_state = ST_FETCH;
         end
         ST_FETCH: next_state = ST_LATCH;
         ST_LATCH: next_state = ST_SEND;
         default: next_state = ST_RX;
      endcase
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) state <= ST_RX;
      else state <= next_state;
   end

   // Driver enable covers the write commit and the whole answer, and nothing else
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) TX_EN <= 1'b0;
      else TX_EN <= (next_state != ST_RX);
   end
   // Readings are frozen at the poll so one reply is self-consistent
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         s_int <= 16'h0000;
         s_mil <= 10'h000;
         l_int <= 16'h0000;
         l_mil <= 10'h000;
      end else if (poll_go) begin
         s_int <= SPEED_INT;
         s_mil <= SPEED_MILLI;
         l_int <= LEVEL_INT;
         l_mil <= LEVEL_MILLI;
      end
   end

   // Byte handshake and running checksums of the reply
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || state == ST_RX) begin
         TX_BYTE <= '0;
         tx_idx <= 8'h00;
         tsum <= 8'h00;
         crc_tx <= `RPR_CRC_INIT;
         fetched <= 1'b0;
      end else if (tx_done) begin
         TX_BYTE.valid <= 1'b0;
         tx_idx <= tx_idx + 8'h01;
         fetched <= 1'b0;
         if (tx_idx >= 8'h01 && tx_idx < 8'(8'h03 + s_len)) tsum <= tsum + TX_BYTE.data;
         if (tx_idx < 8'(tx_len - 8'h02)) crc_tx <= crc_step(crc_tx, TX_BYTE.data);
      end else if (state == ST_SEND && !TX_BYTE.valid && tx_idx != tx_len && !need_fetch) begin
         TX_BYTE <= '{valid: 1'b1, parity: ^tx_data, data: tx_data};
      end else if (state == ST_LATCH) begin
         fetched <= 1'b1;
      end
   end

   // Register port: writes commit before the echo, reads one word per fetch
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST || state == ST_RX) begin
         REG_REQ <= '0;
         wr_k <= 4'h0;
      end else if (state == ST_COMMIT) begin
         REG_REQ.wr <= (wr_k != wr_n);
         REG_REQ.addr <= start + {12'h000, wr_k};
         REG_REQ.wdata <= (fun == `RPR_FN_WRITE1) ? count : wbuf[wr_k[2:0]];
         if (wr_k != wr_n) wr_k <= wr_k + 4'h1;
      end else if (state == ST_FETCH) begin
         REG_REQ.wr <= 1'b0;
         REG_REQ.rd <= 1'b1;
         REG_REQ.addr <= start + {9'h000, tx_off[7:1]};
      end else begin
         REG_REQ.rd <= 1'b0;
         REG_REQ.wr <= 1'b0;
      end
   end

   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) rdata <= 16'h0000;
      else if (state == ST_LATCH) rdata <= REG_RDATA;
   end

   // ***************
   // Assertions
   // ***************
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (SYS_RST);

   sequence seq_poll_accept;
      poll_go && !MODE_MODBUS;
   endsequence
   sequence seq_lead_out;
      TX_BYTE.valid && TX_BYTE.data == `RPR_REPLY_LEAD;
   endsequence

   a_reply_lead: assert property (seq_poll_accept |-> ##[2:3] seq_lead_out) else $error("reply lead missing");
   a_tx_in_reply: assert property (TX_BYTE.valid |-> TX_EN && state == ST_SEND) else $error("unsolicited tx");
   a_bad_id_quiet: assert property (poll_end && !poll_ok |=> state == ST_RX) else $error("reply to foreign id");
   a_save_enter: assert property (poll_ok && cmd == `RPR_SAVE_LEAD |=> POWER_SAVE) else $error("no power save");
   a_save_leave: assert property (poll_ok && cmd == `RPR_WAKE_LEAD |=> !POWER_SAVE) else $error("no wake");
   a_crc_drop: assert property (mb_end && crc_next != 16'h0000 |=> state == ST_RX && !TX_EN) else $error("bad crc answered");
   a_tx_parity: assert property (TX_BYTE.valid |-> TX_BYTE.parity == ^TX_BYTE.data) else $error("odd parity");
   a_tx_hold: assert property (TX_BYTE.valid && !TX_READY |=> TX_BYTE.valid && $stable(TX_BYTE.data))
      else $error("tx byte dropped");
   a_poll_sum: assert property (
      TX_BYTE.valid && !MODE_MODBUS && tx_idx == 8'(tx_len - 8'h01) |-> TX_BYTE.data == tsum)
      else $error("reply checksum wrong");
   a_crc_low: assert property (
      TX_BYTE.valid && MODE_MODBUS && tx_idx == 8'(tx_len - 8'h02) |-> TX_BYTE.data == crc_tx[7:0])
      else $error("reply crc wrong");
   a_read_strobe: assert property ($rose(REG_REQ.rd) |=> !REG_REQ.rd ##1 state == ST_SEND) else $error("read strobe");
endmodule : rpr_poll_responder

// [tb/rpr_logger_model.sv]
// Logger model: polling master that sends request bytes and sinks reply bytes
`timescale 1ns/100ps
module rpr_logger_model (
   input wire logic CLK_SYS,
   input wire logic SYS_RST,
   input wire rpr_pkg::rpr_byte_type TX_BYTE,
   output rpr_pkg::rpr_byte_type RX_BYTE,
   output logic TX_READY
);
   import rpr_pkg::*;
   // ********************************
   // Sink and source of the line
   // ********************************
   logic [8:0] got [$];
   logic slow = 1'b0;
   logic [7:0] lf = 8'h5B;
   initial RX_BYTE = '0;
   initial TX_READY = 1'b0;
   // Random stalls when slow, so the design must hold each byte until taken
   always @(posedge CLK_SYS) begin
      lf <= {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      TX_READY <= !SYS_RST && (!slow || lf[0]);
      if (TX_BYTE.valid && TX_READY) begin
         got.push_back({TX_BYTE.parity, TX_BYTE.data});
      end
   end
   // One character pulse, then idle with inverted leftovers so stale data is never trusted
   task automatic send(input logic [7:0] d, input logic bad_par);
      RX_BYTE <= '{valid: 1'b1, parity: (^d) ^ bad_par, data: d};
      @(posedge CLK_SYS);
      RX_BYTE <= '{valid: 1'b0, parity: ^d, data: ~d};
      repeat (3) @(posedge CLK_SYS);
   endtask : send
endmodule : rpr_logger_model

// [tb/tb_rpr_poll_responder.sv]
// Testbench of the poll responder: poll, power-save and Modbus traffic
`timescale 1ns/100ps
`include "rpr_defs.svh"
module tb_rpr_poll_responder;
   import rpr_pkg::*;
   // ********************************
   // Signals and bookkeeping
   // ********************************
   localparam int GAP = 50;
   logic clk_sys = 1'b0;
   logic sys_rst = 1'b1;
   logic mode_modbus = 1'b0;
   logic [7:0] unit_id = 8'h00;
   logic [15:0] speed_int = 16'h0000;
   logic [9:0] speed_milli = 10'h000;
   logic [15:0] level_int = 16'h0000;
   logic [9:0] level_milli = 10'h000;
   rpr_byte_type rx_byte;
   rpr_byte_type tx_byte;
   logic tx_ready;
   logic tx_en;
   logic power_save;
   rpr_reg_req_type reg_req;
   logic [15:0] reg_rdata;
   logic [31:0] seed = 32'h00010AB1;
   int n_errors = 0;
   int samples_checked = 0;
   logic [7:0] rq [$];
   logic [7:0] ex [$];
   logic [15:0] rd_q [$];
   logic [31:0] wr_q [$];
   rpr_poll_responder #(.GAP_CYCLES(GAP)) dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .MODE_MODBUS(mode_modbus),
      .UNIT_ID(unit_id), .SPEED_INT(speed_int), .SPEED_MILLI(speed_milli), .LEVEL_INT(level_int),
      .LEVEL_MILLI(level_milli), .RX_BYTE(rx_byte), .TX_READY(tx_ready), .TX_BYTE(tx_byte), .TX_EN(tx_en),
      .POWER_SAVE(power_save), .REG_REQ(reg_req), .REG_RDATA(reg_rdata));
   rpr_logger_model lg (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .TX_BYTE(tx_byte), .RX_BYTE(rx_byte),
      .TX_READY(tx_ready));
   initial begin
      forever #4 clk_sys = ~clk_sys;
   end
   // Read data must be there in the strobe cycle, so it is a pure function of the address
   assign reg_rdata = reg_req.addr ^ 16'h5A3C;
   // Log every register strobe for later comparison
   always @(posedge clk_sys) begin
      if (reg_req.rd === 1'b1) rd_q.push_back(reg_req.addr);
      if (reg_req.wr === 1'b1) wr_q.push_back({reg_req.addr, reg_req.wdata});
   end
   // ********************************
   // Compare, expectation and transfer helpers
   // ********************************
   task automatic chk_byte(input logic [8:0] g, input logic [8:0] e);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk_byte
   task automatic chk_word(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk_word
   task automatic stop_test;
      if (n_errors == 0 && samples_checked > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test
   function automatic logic [31:0] rnd;
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction : rnd
   // Integer digits without leading zeros, then dot and three fraction digits
   function automatic void put_num(input logic [15:0] ip, input logic [9:0] mp);
      logic [7:0] t [$];
      int v;
      v = ip;
      do begin
         t.push_front(8'h30 + 8'(v % 10));
         v = v / 10;
      end while (v > 0);
      ex = {ex, t, 8'h2E, 8'h30 + 8'(mp / 100), 8'h30 + 8'(mp / 10 % 10), 8'h30 + 8'(mp % 10)};
   endfunction : put_num
   function automatic void cat_crc(ref logic [7:0] q [$]);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i]) begin
         c ^= {8'h00, q[i]};
         for (int k = 0; k < 8; k++) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
      end
      q = {q, c[7:0], c[15:8]};
   endfunction : cat_crc
   function automatic void pf(input logic [7:0] lead, input logic [15:0] i, input logic [7:0] adj);
      rq = {lead, i[15:8], i[7:0], i[15:8] + i[7:0] + adj};
   endfunction : pf
   function automatic void mb(input logic [7:0] ad, input logic [7:0] fn, input logic [15:0] a,
      input logic [15:0] n);
      rq = {ad, fn, a[15:8], a[7:0], n[15:8], n[7:0]};
      cat_crc(rq);
   endfunction : mb
   // Sends rq, waits for the reply to end or for silence, then checks the bytes against ex
   task automatic run(input int bad);
      logic seen;
      seen = 1'b0;
      lg.got.delete();
      rd_q.delete();
      wr_q.delete();
      @(posedge clk_sys);
      foreach (rq[i]) lg.send(rq[i], i == bad);
      for (int i = 0; i < 3000; i++) begin
         @(posedge clk_sys);
         if (tx_en === 1'b1) seen = 1'b1;
         if ((seen && tx_en === 1'b0) || (!seen && i > GAP + 40)) break;
      end
      repeat (GAP + 5) @(posedge clk_sys);
      chk_word(lg.got.size(), ex.size());
      chk_word({31'h0, seen}, {31'h0, ex.size() != 0});
      foreach (ex[i]) if (i < lg.got.size()) chk_byte(lg.got[i], {^ex[i], ex[i]});
   endtask : run
   // ********************************
   // Main sequence
   // ********************************
   initial begin
      logic [15:0] s, l, a, v, ida;
      logic [9:0] sm, lm;
      logic [7:0] uid, cs;
      repeat (20) @(posedge clk_sys);
      sys_rst <= 1'b0;
      uid = 8'(rnd() % 100);
      unit_id <= uid;
      ida = {8'h30 + 8'(uid / 10), 8'h30 + 8'(uid % 10)};
      for (int k = 0; k < 8; k++) begin
         s = k == 0 ? 16'h0000 : k == 1 ? 16'hFFFF : 16'(rnd());
         sm = k == 0 ? 10'h005 : k == 1 ? 10'h3E7 : 10'(rnd() % 1000);
         l = k == 1 ? 16'h0000 : 16'(rnd() % 64);
         lm = k == 1 ? 10'h3E7 : 10'(rnd() % 1000);
         speed_int <= s;
         speed_milli <= sm;
         level_int <= l;
         level_milli <= lm;
         ex = {`RPR_REPLY_LEAD, ida[15:8], ida[7:0]};
         put_num(s, sm);
         cs = 8'h00;
         for (int i = 1; i < ex.size(); i++) cs += ex[i];
         ex.push_back(8'h3A);
         put_num(l, lm);
         ex.push_back(cs);
         pf(`RPR_POLL_LEAD, ida, 8'h00);
         if (k == 3) rq = {8'h41, 8'h30, rq};
         lg.slow <= k[0];
         run(-1);
      end
      ex = {};
      pf(`RPR_POLL_LEAD, ida ^ 16'h0001, 8'h00);
      run(-1);
      pf(`RPR_POLL_LEAD, ida, 8'h01);
      run(-1);
      pf(`RPR_SAVE_LEAD, ida, 8'h00);
      run(-1);
      chk_word({31'h0, power_save}, 32'h1);
      pf(`RPR_WAKE_LEAD, ida ^ 16'h0001, 8'h00);
      run(-1);
      chk_word({31'h0, power_save}, 32'h1);
      pf(`RPR_WAKE_LEAD, ida, 8'h00);
      run(-1);
      chk_word({31'h0, power_save}, 32'h0);
      mode_modbus <= 1'b1;
      uid = 8'(rnd() % 247 + 1);
      unit_id <= uid;
      for (int k = 1; k < 4; k++) begin
         a = 16'(rnd()) & 16'h0FFF;
         mb(uid, `RPR_FN_READ, a, 16'(k));
         ex = {uid, `RPR_FN_READ, 8'(2 * k)};
         for (int i = 0; i < k; i++) begin
            v = (a + 16'(i)) ^ 16'h5A3C;
            ex = {ex, v[15:8], v[7:0]};
         end
         cat_crc(ex);
         run(-1);
         chk_word(rd_q.size(), k);
         foreach (rd_q[i]) chk_word({16'h0, rd_q[i]}, {16'h0, a + 16'(i)});
      end
      v = 16'(rnd());
      mb(uid, `RPR_FN_WRITE1, a, v);
      ex = rq;
      run(-1);
      chk_word(wr_q.size(), 1);
      chk_word(wr_q[0], {a, v});
      rq = {uid, `RPR_FN_WRITEN, a[15:8], a[7:0], 8'h00, 8'h02, 8'h04, v[15:8], v[7:0], v[7:0], v[15:8]};
      cat_crc(rq);
      ex = {uid, `RPR_FN_WRITEN, a[15:8], a[7:0], 8'h00, 8'h02};
      cat_crc(ex);
      run(-1);
      chk_word(wr_q.size(), 2);
      chk_word(wr_q[1], {a + 16'h0001, v[7:0], v[15:8]});
      ex = {};
      mb(uid, `RPR_FN_WRITE1, a, v);
      rq[$] = rq[$] ^ 8'h01;
      run(-1);
      chk_word(wr_q.size(), 0);
      mb(uid + 8'h01, `RPR_FN_READ, a, 16'h0001);
      run(-1);
      mb(uid, `RPR_FN_READ, a, 16'h0001);
      run(1);
      stop_test();
   end
   // Hang guard, well above the few thousand cycles the sequence needs
   initial begin
      repeat (40000) @(posedge clk_sys);
      n_errors++;
      stop_test();
   end
endmodule : tb_rpr_poll_responder
